//--- logic/uart_baud_tx_rx_core.sv
// one serial channel: prescaler, baud generator, transmit and receive paths, host registers
`timescale 1ns/10ps
`default_nettype none
module uart_baud_tx_rx_core
  import uart_core_pkg::*;
#(
  parameter int DEPTH = 128
) (
  input  wire logic       I_CLOCK,
  input  wire logic       I_NRST,
  input  wire logic       I_CS_N,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  input  wire logic [2:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_RX,
  output logic      [7:0] O_RDATA,
  output logic            O_TX,
  output logic            O_INT
);
  localparam int AW = $clog2(DEPTH);
  typedef logic [AW:0] cnt_t;

  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] l);
    logic [7:0] m;
    m = 8'hff >> (2'h3 - l[1:0]);
    return l[LCR_EPS] ? ^(d & m) : ~^(d & m);
  endfunction : par_bit

  function automatic logic acc(input logic s, input logic [2:0] a, input logic [2:0] off, input logic dl,
                               input logic want);
    return s && (a == off) && (dl == want);
  endfunction : acc

  host_req_t  req;
  logic [7:0] lcr_r, lcr_nxt, ier_r, ier_nxt, mcr_r, mcr_nxt, rdata_r, rdata_nxt;
  logic [1:0] trig_r, trig_nxt;
  logic       fen_r, fen_nxt, thre_int_r, thre_int_nxt, thre_prev_r, thre_prev_nxt, int_r, int_nxt;
  logic [15:0] div_r, div_nxt;
  logic       dlab, wr_thr, rd_rhr, rd_isr, rd_lsr, wr_fcr, tx_flush, rx_flush;
  logic [3:0] dbits;
  logic [7:0] line_status;
  assign req    = '{addr: I_ADDR, wr: !I_CS_N && I_WR, rd: !I_CS_N && I_RD, wdata: I_WDATA};
  assign dlab   = lcr_r[LCR_DLAB];
  assign dbits  = 4'h5 + {2'b00, lcr_r[1:0]};
  assign wr_thr = acc(req.wr, req.addr, OFF_DATA, dlab, 1'b0);
  assign rd_rhr = acc(req.rd, req.addr, OFF_DATA, dlab, 1'b0);
  assign rd_isr = req.rd && req.addr == OFF_ISR;
  assign rd_lsr = req.rd && req.addr == OFF_LSR;
  assign wr_fcr = req.wr && req.addr == OFF_ISR;
  assign tx_flush = wr_fcr && (req.wdata[FCR_TXRST] || req.wdata[FCR_EN] != fen_r);
  assign rx_flush = wr_fcr && (req.wdata[FCR_RXRST] || req.wdata[FCR_EN] != fen_r);

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_NRST);

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and baud generator, clocked from the oscillator clock
  logic [1:0]  pre_r, pre_nxt;
  logic [15:0] brg_r, brg_nxt;
  logic        tick_r, tick_nxt, pre_tick;
  always_comb begin
    pre_tick = 1'b1;
    pre_nxt  = 2'h0;
    if (mcr_r[MCR_PRESC]) begin
      pre_tick = (pre_r == PRESC_MAX);
      pre_nxt  = pre_r + 2'h1;
    end
    tick_nxt = 1'b0;
    brg_nxt  = brg_r;
    if (pre_tick) begin
      if (div_r <= 16'h0001 || brg_r >= div_r - 16'h0001) begin
        brg_nxt  = 16'h0000;
        tick_nxt = 1'b1;
      end else begin
        brg_nxt = brg_r + 16'h0001;
      end
    end
  end
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      pre_r  <= 2'h0;
      brg_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      pre_r  <= pre_nxt;
      brg_r  <= brg_nxt;
      tick_r <= tick_nxt;
    end
  end
  chk_presc_gap: assert property (tick_r && mcr_r[MCR_PRESC] |=> (!tick_r || !mcr_r[MCR_PRESC]) [*3])
    else $error("prescale by four gave ticks too close");
  chk_brg_gap: assert property (tick_r && !mcr_r[MCR_PRESC] && div_r > 16'h0001 && !req.wr |=> !tick_r)
    else $error("baud tick repeated with divisor above one");

  ////////////////////////////////////////////////////////////////////////////
  // transmit fifo and shifter
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
  cnt_t tx_cnt_r, tx_cnt_nxt, cap;
  ser_state_t tx_st_r, tx_st_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic [3:0] tx_sub_r, tx_sub_nxt;
  logic [2:0] tx_bit_r, tx_bit_nxt;
  logic tx_line_r, tx_line_nxt, tx_par_r, tx_par_nxt, tx_push, tx_load, tx_adv;
  assign cap     = fen_r ? cnt_t'(DEPTH) : cnt_t'(1);  // non-fifo mode is a one-deep holding register
  assign tx_push = wr_thr && tx_cnt_r < cap;
  assign tx_load = tx_st_r == S_IDLE && tx_cnt_r != '0 && !tx_flush;
  assign tx_adv  = tick_r && tx_st_r != S_IDLE && tx_sub_r == SAMPLE_END;
  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_sh_nxt = tx_sh_r;
    tx_sub_nxt = tx_sub_r;
    tx_bit_nxt = tx_bit_r;
    tx_line_nxt = tx_line_r;
    tx_par_nxt = tx_par_r;
    tx_wp_nxt = tx_push ? tx_wp_r + AW'(1) : tx_wp_r;
    tx_rp_nxt = tx_load ? tx_rp_r + AW'(1) : tx_rp_r;
    tx_cnt_nxt = cnt_t'(tx_cnt_r + cnt_t'(tx_push) - cnt_t'(tx_load));
    if (tick_r && tx_st_r != S_IDLE) begin
      tx_sub_nxt = tx_sub_r + 4'h1;
    end
    if (tx_load) begin
      tx_sh_nxt = tx_mem[tx_rp_r];
      tx_par_nxt = par_bit(tx_mem[tx_rp_r], lcr_r);
      tx_st_nxt = S_START;
      tx_sub_nxt = 4'h0;
      tx_line_nxt = 1'b0;
    end else if (tx_adv) begin
      unique case (tx_st_r)
        S_START: begin
          tx_st_nxt = S_DATA;
          tx_bit_nxt = 3'h0;
          tx_line_nxt = tx_sh_r[0];
        end
        S_DATA: begin
          tx_sh_nxt = tx_sh_r >> 1;
          tx_bit_nxt = tx_bit_r + 3'h1;
          tx_line_nxt = tx_sh_r[1];
          if ({1'b0, tx_bit_r} == dbits - 4'h1) begin
            tx_st_nxt = lcr_r[LCR_PEN] ? S_PAR : S_STOP;
            tx_line_nxt = lcr_r[LCR_PEN] ? tx_par_r : 1'b1;
            tx_bit_nxt = 3'h0;
          end
        end
        S_PAR: begin
          tx_st_nxt = S_STOP;
          tx_line_nxt = 1'b1;
        end
        S_STOP: begin
          tx_bit_nxt = 3'h1;
          if (!(lcr_r[LCR_STOP] && tx_bit_r == 3'h0)) begin
            tx_st_nxt = S_IDLE;
          end
        end
        S_IDLE: tx_st_nxt = S_IDLE;
      endcase
    end
    if (tx_flush) begin
      tx_wp_nxt = '0;
      tx_rp_nxt = '0;
      tx_cnt_nxt = '0;
    end
  end
  always_ff @(posedge I_CLOCK) begin
    if (tx_push) begin
      tx_mem[tx_wp_r] <= req.wdata;
    end
  end
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_st_r <= S_IDLE;
      tx_sh_r <= 8'h00;
      tx_sub_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_line_r <= 1'b1;
      tx_par_r <= 1'b0;
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= '0;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_sub_r <= tx_sub_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_line_r <= tx_line_nxt;
      tx_par_r <= tx_par_nxt;
      tx_wp_r <= tx_wp_nxt;
      tx_rp_r <= tx_rp_nxt;
      tx_cnt_r <= tx_cnt_nxt;
    end
  end
  chk_tx_bit_edge: assert property ($changed(tx_line_r) |-> $past(tx_adv) || $past(tx_load))
    else $error("transmit line moved off a bit boundary");
  chk_tx_start_bit: assert property (tx_load |=> !tx_line_r && tx_st_r == S_START)
    else $error("no start bit after load");
  chk_tx_fifo_push: assert property (tx_push && !tx_load && !tx_flush |=>
                                     tx_cnt_r == cnt_t'($past(tx_cnt_r) + cnt_t'(1)))
    else $error("holding write did not push");
  chk_thre_on_move: assert property (tx_load && tx_cnt_r == cnt_t'(1) && !wr_thr |=> line_status[LSR_THRE])
    else $error("holding empty not set after move to shifter");
  chk_temt_busy: assert property (tx_st_r != S_IDLE |-> !line_status[LSR_TEMT])
    else $error("transmitter empty while shifting");

  ////////////////////////////////////////////////////////////////////////////
  // receiver: start validation, mid-bit sampling, fifo with error tags, timeout
  rx_entry_t rx_mem [DEPTH];
  logic [AW-1:0] rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
  cnt_t rx_cnt_r, rx_cnt_nxt, trig;
  ser_state_t rx_st_r, rx_st_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic [3:0] rx_sub_r, rx_sub_nxt;
  logic [2:0] rx_bit_r, rx_bit_nxt;
  logic [9:0] tmo_r, tmo_nxt, tmo_lim;
  logic rx_prev_r, rx_prev_nxt, rx_pe_r, rx_pe_nxt, rx_zero_r, rx_zero_nxt, oe_r, oe_nxt, tmo_f_r, tmo_f_nxt;
  logic rx_smp, rx_done, rx_push, rx_pop, rx_hit;
  rx_entry_t rx_new, rx_head;
  assign rx_smp  = tick_r && (rx_st_r == S_START ? rx_sub_r == SAMPLE_MID : rx_sub_r == SAMPLE_END);
  assign rx_done = rx_smp && rx_st_r == S_STOP;
  assign rx_push = rx_done && rx_cnt_r < cap && !rx_flush;
  assign rx_pop  = rd_rhr && rx_cnt_r != '0 && !rx_flush;
  assign rx_new  = '{brk: rx_zero_r && !I_RX, frm: !I_RX, par: rx_pe_r,
                     data: rx_sh_r >> (2'h3 - lcr_r[1:0])};
  assign rx_head = rx_mem[rx_rp_r];
  assign tmo_lim = 10'((TMO_CHARS * (32'(dbits) + 2) + TMO_EXTRA_BITS) * TICKS_PER_BIT);
  assign trig    = trig_r == 2'h0 ? cnt_t'(TRIG_L0) : trig_r == 2'h1 ? cnt_t'(TRIG_L1) :
                   trig_r == 2'h2 ? cnt_t'(TRIG_L2) : cnt_t'(TRIG_L3);
  assign rx_hit  = fen_r ? rx_cnt_r >= trig : rx_cnt_r != '0;
  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_sh_nxt = rx_sh_r;
    rx_bit_nxt = rx_bit_r;
    rx_pe_nxt = rx_pe_r;
    rx_zero_nxt = rx_zero_r;
    rx_prev_nxt = I_RX;
    rx_sub_nxt = (tick_r && rx_st_r != S_IDLE) ? rx_sub_r + 4'h1 : rx_sub_r;
    rx_wp_nxt = rx_push ? rx_wp_r + AW'(1) : rx_wp_r;
    rx_rp_nxt = rx_pop ? rx_rp_r + AW'(1) : rx_rp_r;
    rx_cnt_nxt = cnt_t'(rx_cnt_r + cnt_t'(rx_push) - cnt_t'(rx_pop));
    // a byte dropped by a flush is not an overrun; set wins over clear
    oe_nxt = (rx_done && !rx_push && !rx_flush) || (oe_r && !rd_lsr);
    if (rx_st_r == S_IDLE && rx_prev_r && !I_RX) begin
      rx_st_nxt = S_START;
      rx_sub_nxt = 4'h0;
    end else if (rx_smp) begin
      unique case (rx_st_r)
        S_START: begin
          rx_st_nxt = I_RX ? S_IDLE : S_DATA;
          rx_sub_nxt = 4'h0;
          rx_bit_nxt = 3'h0;
          rx_zero_nxt = 1'b1;
          rx_pe_nxt = 1'b0;
        end
        S_DATA: begin
          rx_sh_nxt = {I_RX, rx_sh_r[7:1]};
          rx_zero_nxt = rx_zero_r && !I_RX;
          rx_bit_nxt = rx_bit_r + 3'h1;
          if ({1'b0, rx_bit_r} == dbits - 4'h1) begin
            rx_st_nxt = lcr_r[LCR_PEN] ? S_PAR : S_STOP;
          end
        end
        S_PAR: begin
          rx_pe_nxt = par_bit(rx_sh_r >> (2'h3 - lcr_r[1:0]), lcr_r) != I_RX;
          rx_zero_nxt = rx_zero_r && !I_RX;
          rx_st_nxt = S_STOP;
        end
        S_STOP: rx_st_nxt = S_IDLE;
        S_IDLE: rx_st_nxt = S_IDLE;
      endcase
    end
    tmo_nxt = tmo_r;
    tmo_f_nxt = tmo_f_r && !rd_rhr;
    if (rx_cnt_r == '0 || rx_push || rd_rhr || !fen_r) begin
      tmo_nxt = 10'h000;
    end else if (tick_r && !tmo_f_r) begin
      tmo_nxt = tmo_r + 10'h001;
      tmo_f_nxt = tmo_r == tmo_lim - 10'h001;
    end
    if (rx_flush) begin
      rx_wp_nxt = '0;
      rx_rp_nxt = '0;
      rx_cnt_nxt = '0;
      tmo_f_nxt = 1'b0;
    end
  end
  always_ff @(posedge I_CLOCK) begin
    if (rx_push) begin
      rx_mem[rx_wp_r] <= rx_new;
    end
  end
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      rx_st_r <= S_IDLE;
      rx_sh_r <= 8'h00;
      rx_sub_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_pe_r <= 1'b0;
      rx_zero_r <= 1'b0;
      rx_prev_r <= 1'b1;
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= '0;
      oe_r <= 1'b0;
      tmo_r <= 10'h000;
      tmo_f_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_sub_r <= rx_sub_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_pe_r <= rx_pe_nxt;
      rx_zero_r <= rx_zero_nxt;
      rx_prev_r <= rx_prev_nxt;
      rx_wp_r <= rx_wp_nxt;
      rx_rp_r <= rx_rp_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      oe_r <= oe_nxt;
      tmo_r <= tmo_nxt;
      tmo_f_r <= tmo_f_nxt;
    end
  end
  sequence s_start_mid;
    rx_st_r == S_START && rx_smp;
  endsequence
  chk_false_start: assert property (s_start_mid ##0 I_RX |=> rx_st_r == S_IDLE)
    else $error("false start not discarded");
  chk_start_valid: assert property (s_start_mid ##0 !I_RX |=> rx_st_r == S_DATA && rx_sub_r == 4'h0)
    else $error("valid start not accepted");
  chk_rx_store: assert property (rx_push && !rx_pop |=> rx_cnt_r == cnt_t'($past(rx_cnt_r) + cnt_t'(1)))
    else $error("received byte not stored");
  chk_tmo_limit: assert property ($rose(tmo_f_r) |-> $past(tmo_r) == tmo_lim - 10'h001)
    else $error("timeout at wrong count");
  chk_tmo_clear: assert property (rd_rhr && !rx_flush |=> !tmo_f_r && tmo_r == 10'h000)
    else $error("read did not clear timeout");

  ////////////////////////////////////////////////////////////////////////////
  // host registers, status and interrupt
  logic [3:0] isr_code;
  logic thre;
  assign thre = tx_cnt_r == '0;
  assign line_status = {1'b0, thre && tx_st_r == S_IDLE,
                thre, rx_cnt_r != '0 ? {rx_head.brk, rx_head.frm, rx_head.par} : 3'b000,
                oe_r, rx_cnt_r != '0};
  always_comb begin
    isr_code = ISR_NONE;
    if (ier_r[IER_RX] && tmo_f_r) begin
      isr_code = ISR_TMO;
    end else if (ier_r[IER_RX] && rx_hit) begin
      isr_code = ISR_RXRDY;
    end else if (ier_r[IER_TX] && thre_int_r) begin
      isr_code = ISR_THRE;
    end
    lcr_nxt = (req.wr && req.addr == OFF_LCR) ? req.wdata : lcr_r;
    mcr_nxt = (req.wr && req.addr == OFF_MCR) ? req.wdata : mcr_r;
    ier_nxt = acc(req.wr, req.addr, OFF_IER, dlab, 1'b0) ? {6'h00, req.wdata[1:0]} : ier_r;
    div_nxt = div_r;
    if (acc(req.wr, req.addr, OFF_DATA, dlab, 1'b1)) begin
      div_nxt[7:0] = req.wdata;
    end
    if (acc(req.wr, req.addr, OFF_IER, dlab, 1'b1)) begin
      div_nxt[15:8] = req.wdata;
    end
    fen_nxt = wr_fcr ? req.wdata[FCR_EN] : fen_r;
    trig_nxt = wr_fcr ? req.wdata[7:6] : trig_r;
    thre_prev_nxt = thre;
    // holding-empty event sets; a write to holding or a status read that reports it clears; set wins
    thre_int_nxt = (thre && (!thre_prev_r || (ier_nxt[IER_TX] && !ier_r[IER_TX]))) ||
                   (thre_int_r && !wr_thr && !(rd_isr && isr_code == ISR_THRE));
    rdata_nxt = rdata_r;
    if (req.rd) begin
      unique case (req.addr)
        OFF_DATA: rdata_nxt = dlab ? div_r[7:0] : rx_head.data;
        OFF_IER:  rdata_nxt = dlab ? div_r[15:8] : ier_r;
        OFF_ISR:  rdata_nxt = {fen_r, fen_r, 2'b00, isr_code};
        OFF_LCR:  rdata_nxt = lcr_r;
        OFF_MCR:  rdata_nxt = mcr_r;
        OFF_LSR:  rdata_nxt = line_status;
        default:  rdata_nxt = 8'h00;
      endcase
    end
    int_nxt = isr_code != ISR_NONE;
  end
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      lcr_r <= REG_RST;
      mcr_r <= REG_RST;
      ier_r <= REG_RST;
      div_r <= DIV_RST;
      fen_r <= 1'b0;
      trig_r <= 2'h0;
      thre_prev_r <= 1'b1;
      thre_int_r <= 1'b0;
      rdata_r <= 8'h00;
      int_r <= 1'b0;
    end else begin
      lcr_r <= lcr_nxt;
      mcr_r <= mcr_nxt;
      ier_r <= ier_nxt;
      div_r <= div_nxt;
      fen_r <= fen_nxt;
      trig_r <= trig_nxt;
      thre_prev_r <= thre_prev_nxt;
      thre_int_r <= thre_int_nxt;
      rdata_r <= rdata_nxt;
      int_r <= int_nxt;
    end
  end
  assign O_RDATA = rdata_r;
  assign O_TX    = tx_line_r;
  assign O_INT   = int_r;
  chk_thre_irq: assert property (thre_int_r && ier_r[IER_TX] |=> O_INT)
    else $error("holding empty interrupt missing");
  chk_rx_irq: assert property (rx_hit && ier_r[IER_RX] |=> O_INT)
    else $error("data ready interrupt missing");
endmodule : uart_baud_tx_rx_core
`default_nettype wire

//--- logic/uart_core_pkg.sv
// shared constants, types and register map of the serial channel core
package uart_core_pkg;
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_IER  = 3'h1;
  localparam logic [2:0] OFF_ISR  = 3'h2;
  localparam logic [2:0] OFF_LCR  = 3'h3;
  localparam logic [2:0] OFF_MCR  = 3'h4;
  localparam logic [2:0] OFF_LSR  = 3'h5;
  localparam int MCR_PRESC  = 7;
  localparam int FCR_EN     = 0;
  localparam int FCR_RXRST  = 1;
  localparam int FCR_TXRST  = 2;
  localparam int IER_RX     = 0;
  localparam int IER_TX     = 1;
  localparam int LCR_STOP   = 2;
  localparam int LCR_PEN    = 3;
  localparam int LCR_EPS    = 4;
  localparam int LCR_DLAB   = 7;
  localparam int LSR_THRE   = 5;
  localparam int LSR_TEMT   = 6;
  localparam logic [7:0]  REG_RST  = 8'h00;
  localparam logic [15:0] DIV_RST  = 16'h0001;
  localparam logic [3:0]  ISR_NONE = 4'h1;
  localparam logic [3:0]  ISR_THRE = 4'h2;
  localparam logic [3:0]  ISR_RXRDY = 4'h4;
  localparam logic [3:0]  ISR_TMO  = 4'hc;
  localparam logic [1:0]  PRESC_MAX  = 2'h3;
  localparam logic [3:0]  SAMPLE_MID = 4'h7;
  localparam logic [3:0]  SAMPLE_END = 4'hf;
  localparam int TMO_CHARS      = 4;
  localparam int TMO_EXTRA_BITS = 12;
  localparam int TICKS_PER_BIT  = 16;
  localparam int TRIG_L0 = 1;
  localparam int TRIG_L1 = 32;
  localparam int TRIG_L2 = 64;
  localparam int TRIG_L3 = 120;
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_START = 3'b001,
    S_DATA  = 3'b010,
    S_PAR   = 3'b011,
    S_STOP  = 3'b100
  } ser_state_t;
  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } rx_entry_t;
  typedef struct packed {
    logic [2:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } host_req_t;
endpackage : uart_core_pkg

//--- verif/serial_peer.sv
// remote serial device: decodes frames on the core's transmit line, sends frames into its receive line
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
  input  wire logic        i_clk,
  input  wire logic        i_line,
  input  wire logic [15:0] i_bit_clks,
  input  wire logic [3:0]  i_nbits,
  output logic             o_line,
  output logic [7:0]       o_byte,
  output logic             o_stop,
  output logic [7:0]       o_count
);
  initial begin
    o_line  = 1'b1;
    o_byte  = 8'h00;
    o_stop  = 1'b0;
    o_count = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  // centre of start bit, then one sample per bit period
  initial begin : rx_proc
    logic [7:0] b;
    forever begin
      @(negedge i_line);
      repeat (i_bit_clks / 2) @(posedge i_clk);
      if (i_line === 1'b0) begin
        b = 8'h00;
        for (int i = 0; i < i_nbits; i++) begin
          repeat (i_bit_clks) @(posedge i_clk);
          b[i] = i_line;
        end
        repeat (i_bit_clks) @(posedge i_clk);
        o_stop  = i_line;
        o_byte  = b;
        o_count = o_count + 8'h01;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  // start, data lsb first, one stop bit, one idle bit; line idles high
  task automatic send(input logic [7:0] d, input logic stop_bit);
    @(posedge i_clk);
    o_line <= 1'b0;
    repeat (i_bit_clks) @(posedge i_clk);
    for (int i = 0; i < i_nbits; i++) begin
      o_line <= d[i];
      repeat (i_bit_clks) @(posedge i_clk);
    end
    o_line <= stop_bit;
    repeat (i_bit_clks) @(posedge i_clk);
    o_line <= 1'b1;
    repeat (i_bit_clks) @(posedge i_clk);
  endtask : send
  // short low pulse that must be taken for a false start
  task automatic glitch(input int n);
    @(posedge i_clk);
    o_line <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_line <= 1'b1;
  endtask : glitch
endmodule : serial_peer
`default_nettype wire

//--- verif/uart_baud_tx_rx_core_test.sv
// self-checking bench of the serial channel core with a remote serial device
`timescale 1ns/10ps
`default_nettype none
module uart_baud_tx_rx_core_test;
  import uart_core_pkg::*;
  logic        clk, nrst, cs_n, wr, rd, rx, tx, intr, pstop;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, pbyte, pcount, v, c0;
  logic [15:0] bit_clks;
  logic [3:0]  nbits;
  int          errors, total_checks;

  uart_baud_tx_rx_core u_dut (.I_CLOCK(clk), .I_NRST(nrst), .I_CS_N(cs_n), .I_WR(wr), .I_RD(rd),
    .I_ADDR(addr), .I_WDATA(wdata), .I_RX(rx), .O_RDATA(rdata), .O_TX(tx), .O_INT(intr));
  serial_peer u_peer (.i_clk(clk), .i_line(tx), .i_bit_clks(bit_clks), .i_nbits(nbits),
    .o_line(rx), .o_byte(pbyte), .o_stop(pstop), .o_count(pcount));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    cs_n  <= 1'b0;
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    cs_n <= 1'b1;
    wr   <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    cs_n <= 1'b1;
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : reg_rd
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_rd(a, d);
    chk(d, exp);
  endtask : rd_chk
  task automatic set_div(input logic [7:0] lo, input logic [7:0] hi);
    reg_wr(OFF_LCR, 8'h83);
    reg_wr(OFF_DATA, lo);
    reg_wr(OFF_IER, hi);
    reg_wr(OFF_LCR, 8'h03);
  endtask : set_div
  // bounded wait for the peer to decode n frames, then let the stop bit end
  task automatic wait_tx(input logic [7:0] n);
    for (int k = 0; k < 3000 && pcount !== n; k++) begin
      @(posedge clk);
    end
    chk(pcount, n);
    repeat (bit_clks) @(posedge clk);
  endtask : wait_tx
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    cs_n = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    bit_clks = 16'd32;
    nbits = 4'd8;
    errors = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(OFF_LSR, 8'h60);
    rd_chk(OFF_ISR, 8'h01);
    rd_chk(3'h6, 8'h00);
    set_div(8'h02, 8'h00);
    rd_chk(OFF_LCR, 8'h03);
    // non-fifo transmit with holding-empty interrupt
    reg_wr(OFF_IER, 8'h02);
    c0 = pcount;
    reg_wr(OFF_DATA, 8'ha5);
    repeat (3) @(posedge clk);
    rd_chk(OFF_LSR, 8'h20);
    chk({7'h00, intr}, 8'h01);
    rd_chk(OFF_ISR, 8'h02);
    wait_tx(c0 + 8'h01);
    chk(pbyte, 8'ha5);
    rd_chk(OFF_LSR, 8'h60);
    reg_wr(OFF_IER, 8'h00);
    // prescale by four: 64 clocks a bit with divisor 1
    reg_wr(OFF_MCR, 8'h80);
    set_div(8'h01, 8'h00);
    bit_clks = 16'd64;
    c0 = pcount;
    reg_wr(OFF_DATA, 8'h5a);
    wait_tx(c0 + 8'h01);
    chk(pbyte, 8'h5a);
    reg_wr(OFF_MCR, 8'h00);
    set_div(8'h02, 8'h00);
    bit_clks = 16'd32;
    // receive, false start, framing error
    u_peer.send(8'h3c, 1'b1);
    rd_chk(OFF_LSR, 8'h61);
    rd_chk(OFF_DATA, 8'h3c);
    u_peer.glitch(6);
    repeat (400) @(posedge clk);
    rd_chk(OFF_LSR, 8'h60);
    u_peer.send(8'h55, 1'b0);
    rd_chk(OFF_LSR, 8'h69);
    rd_chk(OFF_DATA, 8'h55);
    // seven data bits both ways
    reg_wr(OFF_LCR, 8'h02);
    nbits = 4'd7;
    u_peer.send(8'h4b, 1'b1);
    rd_chk(OFF_DATA, 8'h4b);
    c0 = pcount;
    reg_wr(OFF_DATA, 8'h46);
    wait_tx(c0 + 8'h01);
    chk(pbyte, 8'h46);
    chk({7'h00, pstop}, 8'h01);
    // fifo mode transmit
    reg_wr(OFF_LCR, 8'h03);
    nbits = 4'd8;
    reg_wr(OFF_ISR, 8'h01);
    c0 = pcount;
    reg_wr(OFF_DATA, 8'h31);
    reg_wr(OFF_DATA, 8'h32);
    reg_wr(OFF_DATA, 8'h33);
    reg_rd(OFF_LSR, v);
    chk(v & 8'h60, 8'h00);
    wait_tx(c0 + 8'h03);
    chk(pbyte, 8'h33);
    rd_chk(OFF_LSR, 8'h60);
    // fifo receive: head tags, data ready, timeout
    reg_wr(OFF_IER, 8'h01);
    u_peer.send(8'h11, 1'b0);
    u_peer.send(8'h22, 1'b1);
    chk({7'h00, intr}, 8'h01);
    rd_chk(OFF_LSR, 8'h69);
    rd_chk(OFF_ISR, 8'hc4);
    rd_chk(OFF_DATA, 8'h11);
    rd_chk(OFF_LSR, 8'h61);
    // timeout is 52 bit times of 32 clocks after the last read
    repeat (1550) @(posedge clk);
    rd_chk(OFF_ISR, 8'hc4);
    repeat (200) @(posedge clk);
    rd_chk(OFF_ISR, 8'hcc);
    rd_chk(OFF_DATA, 8'h22);
    rd_chk(OFF_ISR, 8'hc1);
    // trigger 32, even parity on seven data bits; the peer takes the parity bit as bit 7
    reg_wr(OFF_ISR, 8'h41);
    reg_wr(OFF_LCR, 8'h1a);
    u_peer.send(8'h46, 1'b1);
    rd_chk(OFF_ISR, 8'hc1);
    chk({7'h00, intr}, 8'h00);
    rd_chk(OFF_LSR, 8'h65);
    rd_chk(OFF_DATA, 8'h46);
    // all-zero frame with low stop bit is a break with framing error
    u_peer.send(8'h00, 1'b0);
    rd_chk(OFF_LSR, 8'h79);
    rd_chk(OFF_DATA, 8'h00);
    c0 = pcount;
    reg_wr(OFF_DATA, 8'h46);
    wait_tx(c0 + 8'h01);
    chk(pbyte, 8'hc6);
    test_done();
  end
endmodule : uart_baud_tx_rx_core_test
`default_nettype wire
